// File: common/quad_uart_host_defines.svh
// Purpose: Shared constants of the quad UART host bus front end
// Assumes: Included by bare name from common/
// Notes:   Definitions only
`ifndef QUAD_UART_HOST_DEFINES_SVH
`define QUAD_UART_HOST_DEFINES_SVH

// Level of the bus-style pin that picks each style
`define QU_STYLE_16_LEVEL     1'b1
`define QU_STYLE_68_LEVEL     1'b0

// Value the internal pull-up gives an undriven bus-style pin
`define QU_STYLE_PULL_LEVEL   1'b1

// Field positions of the synchronised pin bundle
`define QU_PIN_DATA_LSB       0
`define QU_PIN_REGSEL_LSB     8
`define QU_PIN_CHSEL_LSB      11
`define QU_PIN_CS0_BIT        13
`define QU_PIN_CS3_BIT        14
`define QU_PIN_RST_BIT        15
`define QU_PIN_WR_BIT         16
`define QU_PIN_RD_BIT         17
`define QU_PIN_STYLE_BIT      18
`define QU_PIN_WIDTH          19

// Reset value of the pin bundle: strobes and selects idle high
`define QU_PIN_RESET          19'h7F800

// Reset values of the block's own state
`define QU_DATA_RESET         8'h00
`define QU_REGSEL_RESET       3'h0
`define QU_CHSEL_RESET        4'h0

`endif

// File: common/quad_uart_host_pkg.sv
// Purpose: Types of the quad UART host bus front end
// Assumes: Nothing
// Notes:   Constants live in quad_uart_host_defines.svh
package quad_uart_host_pkg;

  typedef enum logic {
    STYLE_68,
    STYLE_16
  } bus_style_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } access_state_t;

endpackage : quad_uart_host_pkg

// File: hw/pin_sync.sv
// Purpose: Two-stage synchroniser for a bundle of host pins
// Assumes: Pins are asynchronous to clock
// Notes:   First stage is read only by the second stage
module pin_sync
  #(parameter int          WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0)
  (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] pin_sync_out
  );

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          meta_q[i]   <= RESET_VAL[i];
          stable_q[i] <= RESET_VAL[i];
        end else begin
          meta_q[i]   <= pin_in[i];
          stable_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pin_sync_out = stable_q;

endmodule : pin_sync

// File: hw/quad_uart_host_bus_select.sv
// Purpose: Host bus front end of a four-channel UART, two bus styles
// Assumes: Host pins are asynchronous and pass two flip-flops first
// Notes:   Channel register contents and interrupt sources sit behind the block
//
// Contract
// - Bus-style pin high selects the strobe 16-style bus, low the read/write 68-style bus.
// - An undriven bus-style pin is pulled high, giving the 16-style bus.
// - In 68-style the write strobe is the read/write line, reset is active low, read strobe ignored.
// - In 68-style the four channel interrupts are ORed onto one open-source request output.
// - The low three address pins choose the register of the selected channel in both styles.
// - In 68-style the two upper address pins pick the channel only while chip select is low.
// - In 16-style the two upper address pins are the active-low selects of channels two and three.
// - In 68-style chip select low enables all channels and the channel bits make the final choice.
// - In 16-style the common chip select is the active-low select of the first channel.
// - In 16-style a falling read strobe drives the chosen register onto the eight data lines.
// - A 16-style channel interrupt is high only with modem-control bit 3, source enabled and a condition.
// - Data bit 0 is the least significant bit and is carried unchanged to the channel.
module quad_uart_host_bus_select
  import quad_uart_host_pkg::*;
  #(parameter int NUM_CHANNELS = 4,
    parameter int DATA_W       = 8)
  (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  // Bus-style select pin and its pull-up
  input  wire logic                       bus_style_level,
  input  wire logic                       bus_style_driven,
  // Host strobes, selects and reset pin
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  input  wire logic                       reset_pin,
  input  wire logic                       first_channel_select_n,
  input  wire logic                       fourth_channel_select_n,
  input  wire logic [1:0]                 channel_sel_bits,
  input  wire logic                       reg_sel_bit0,
  input  wire logic                       reg_sel_bit1,
  input  wire logic                       reg_sel_bit2,
  // Host data bus, split into its three signals
  input  wire logic [DATA_W-1:0]          host_bus_lines_in,
  output      logic [DATA_W-1:0]          host_bus_lines_out,
  output      logic                       host_bus_lines_oe,
  // Interrupt pins
  output      logic [NUM_CHANNELS-1:0]    channel_irq,
  output      logic                       combined_irq_out,
  output      logic                       combined_irq_oe,
  // Channel side: access
  output      logic [NUM_CHANNELS-1:0]    chan_select,
  output      logic [2:0]                 chan_reg_addr,
  output      logic                       chan_read_pulse,
  output      logic                       chan_write_pulse,
  output      logic [DATA_W-1:0]          chan_write_data,
  input  wire logic [NUM_CHANNELS*DATA_W-1:0] chan_read_data,
  output      logic                       chan_reset,
  output      logic                       style_is_16,
  // Channel side: interrupt state
  input  wire logic [NUM_CHANNELS-1:0]    modem_control_reg_bit3,
  input  wire logic [NUM_CHANNELS-1:0]    irq_enable_reg_hit,
  input  wire logic [NUM_CHANNELS-1:0]    irq_condition
  );

  `include "quad_uart_host_defines.svh"

  if (NUM_CHANNELS != 4 || DATA_W != 8) begin : g_bad_params
    $error("quad_uart_host_bus_select serves four eight-bit channels only");
  end

  // Channel choice in either style
  function automatic logic [3:0] decode_select(input bus_style_t style,
                                               input logic       cs0_n,
                                               input logic [1:0] upper,
                                               input logic       cs3_n);
    logic [3:0] sel;
    sel = 4'h0;
    if (style == STYLE_16) begin
      sel[0] = ~cs0_n;
      sel[1] = ~upper[0];
      sel[2] = ~upper[1];
      sel[3] = ~cs3_n;
    end else if (!cs0_n) begin
      sel = 4'h1 << upper;
    end
    return sel;
  endfunction : decode_select

  // Index of the lowest set select; the host is expected to raise one only
  function automatic logic [1:0] select_index(input logic [3:0] sel);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (sel[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : select_index

  // Pin synchronisation
  logic [`QU_PIN_WIDTH-1:0] pins_raw;
  logic [`QU_PIN_WIDTH-1:0] pins;
  logic                     style_pin;

  // Weak pull-up: an undriven pin reads high
  assign style_pin = bus_style_driven ? bus_style_level : `QU_STYLE_PULL_LEVEL;

  assign pins_raw = {style_pin, read_strobe_n, write_strobe_n, reset_pin,
                     fourth_channel_select_n, first_channel_select_n, channel_sel_bits,
                     reg_sel_bit2, reg_sel_bit1, reg_sel_bit0, host_bus_lines_in};

  pin_sync #(
    .WIDTH     (`QU_PIN_WIDTH),
    .RESET_VAL (`QU_PIN_RESET)
  ) u_pin_sync (
    .clock        (clock),
    .rst_n        (rst_n),
    .pin_in       (pins_raw),
    .pin_sync_out (pins)
  );

  // Decoded pin fields
  bus_style_t         style;
  logic               rd_n;
  logic               rw;
  logic               rst_level;
  logic [3:0]         sel_now;
  logic [2:0]         reg_now;
  logic [DATA_W-1:0]  data_now;
  logic               read_active;
  logic               write_active;

  assign style     = (pins[`QU_PIN_STYLE_BIT] == `QU_STYLE_16_LEVEL) ? STYLE_16 : STYLE_68;
  assign rd_n      = pins[`QU_PIN_RD_BIT];
  assign rw        = pins[`QU_PIN_WR_BIT];
  assign rst_level = pins[`QU_PIN_RST_BIT];
  assign reg_now   = pins[`QU_PIN_REGSEL_LSB +: 3];
  assign data_now  = pins[`QU_PIN_DATA_LSB +: DATA_W];
  assign sel_now   = decode_select(style, pins[`QU_PIN_CS0_BIT],
                                   pins[`QU_PIN_CHSEL_LSB +: 2], pins[`QU_PIN_CS3_BIT]);

  // 68-style: read strobe is not looked at; the write pin is the direction
  always_comb begin
    if (style == STYLE_16) begin
      read_active  = !rd_n && (|sel_now);
      write_active = !rw && (|sel_now);
    end else begin
      read_active  = (|sel_now) && rw;
      write_active = (|sel_now) && !rw;
    end
  end

  // Access sequencing
  access_state_t      state_q;
  logic [3:0]         sel_q;
  logic [2:0]         reg_q;
  logic [DATA_W-1:0]  rd_data_q;
  logic [DATA_W-1:0]  wr_data_q;
  logic               oe_q;
  logic               rd_arm_q;
  logic               rd_pulse_q;
  logic               wr_pulse_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ACC_IDLE;
    end else begin
      case (state_q)
        ACC_IDLE: begin
          if (read_active) begin
            state_q <= ACC_READ;
          end else if (write_active) begin
            state_q <= ACC_WRITE;
          end
        end
        ACC_READ: begin
          if (!read_active) begin
            state_q <= ACC_IDLE;
          end
        end
        ACC_WRITE: begin
          if (!write_active) begin
            state_q <= ACC_IDLE;
          end
        end
        default: begin
          state_q <= ACC_IDLE;
        end
      endcase
    end
  end

  // Select and register address are held for the whole access
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_q <= `QU_CHSEL_RESET;
      reg_q <= `QU_REGSEL_RESET;
    end else if (state_q == ACC_IDLE && (read_active || write_active)) begin
      sel_q <= sel_now;
      reg_q <= reg_now;
    end else if (state_q == ACC_IDLE) begin
      sel_q <= `QU_CHSEL_RESET;
    end
  end

  // Read data is taken once, a cycle after the access starts, when chan_reg_addr
  // already names the new register; earlier it would return the old register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_q <= `QU_DATA_RESET;
      oe_q      <= 1'b0;
    end else begin
      if (rd_arm_q) begin
        rd_data_q <= chan_read_data[select_index(sel_q)*DATA_W +: DATA_W];
      end
      oe_q <= read_active && (state_q == ACC_READ);
    end
  end

  // Write data follows the bus until the trailing edge ends the access
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_data_q <= `QU_DATA_RESET;
    end else if (write_active) begin
      wr_data_q <= data_now;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_arm_q   <= 1'b0;
      rd_pulse_q <= 1'b0;
      wr_pulse_q <= 1'b0;
    end else begin
      rd_arm_q   <= (state_q == ACC_IDLE) && read_active;
      rd_pulse_q <= rd_arm_q;
      wr_pulse_q <= (state_q == ACC_WRITE) && !write_active;
    end
  end

  // Reset pin polarity depends on the style
  logic chan_reset_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chan_reset_q <= 1'b1;
    end else begin
      chan_reset_q <= (style == STYLE_16) ? rst_level : !rst_level;
    end
  end

  // Interrupts: per-channel pins in 16-style, one shared request in 68-style
  logic [NUM_CHANNELS-1:0] irq_q;
  logic                    combined_q;
  logic [NUM_CHANNELS-1:0] irq_live;

  assign irq_live = modem_control_reg_bit3 & irq_enable_reg_hit & irq_condition;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_q      <= '0;
      combined_q <= 1'b0;
    end else begin
      irq_q      <= (style == STYLE_16) ? irq_live : '0;
      combined_q <= (style == STYLE_68) && (|(irq_enable_reg_hit & irq_condition));
    end
  end

  // Outputs
  assign host_bus_lines_out = rd_data_q;
  assign host_bus_lines_oe  = oe_q;
  assign channel_irq        = irq_q;
  // Open source: drives high while pending, floats otherwise
  assign combined_irq_out   = combined_q;
  assign combined_irq_oe    = combined_q;
  assign chan_select        = sel_q;
  assign chan_reg_addr      = reg_q;
  assign chan_read_pulse    = rd_pulse_q;
  assign chan_write_pulse   = wr_pulse_q;
  assign chan_write_data    = wr_data_q;
  assign chan_reset         = chan_reset_q;
  assign style_is_16        = (style == STYLE_16);

endmodule : quad_uart_host_bus_select

// File: dv/quad_uart_host_checker.sv
// Purpose: Port assertions for the host bus front end
// Assumes: Bound to quad_uart_host_bus_select
// Notes:   Interrupt outputs lag their causes by one cycle
module quad_uart_host_checker
  #(parameter int NUM_CHANNELS = 4,
    parameter int DATA_W       = 8)
  (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst_n,
  // Watched ports
  input wire logic                    style_is_16,
  input wire logic [NUM_CHANNELS-1:0] channel_irq,
  input wire logic                    combined_irq_out,
  input wire logic                    combined_irq_oe,
  input wire logic [NUM_CHANNELS-1:0] modem_control_reg_bit3,
  input wire logic [NUM_CHANNELS-1:0] irq_enable_reg_hit,
  input wire logic [NUM_CHANNELS-1:0] irq_condition,
  input wire logic                    chan_read_pulse,
  input wire logic                    chan_write_pulse,
  input wire logic [NUM_CHANNELS-1:0] chan_select,
  input wire logic                    host_bus_lines_oe,
  input wire logic [DATA_W-1:0]       host_bus_lines_out
  );
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // First edge after release still shows reset values
  chk_irq_gate_16: assert property ($past(rst_n) |-> channel_irq == ($past(style_is_16) ?
    $past(modem_control_reg_bit3 & irq_enable_reg_hit & irq_condition) : '0))
    else $error("channel irq mismatch");
  chk_irq_wired_or: assert property ($past(rst_n) |-> combined_irq_out ==
    (!$past(style_is_16) && |$past(irq_enable_reg_hit & irq_condition)))
    else $error("combined irq mismatch");
  chk_irq_oe_pair: assert property (combined_irq_oe == combined_irq_out)
    else $error("combined irq enable differs from level");
  chk_read_rise_oe: assert property ($rose(host_bus_lines_oe) |-> chan_read_pulse)
    else $error("bus driven without read pulse");
  chk_read_pulse_one: assert property (chan_read_pulse |=> !chan_read_pulse)
    else $error("read pulse longer than one cycle");
  chk_write_pulse_one: assert property (chan_write_pulse |=> (!chan_write_pulse)[*2])
    else $error("write pulse repeated");
  chk_oe_data_held: assert property (host_bus_lines_oe && $past(host_bus_lines_oe)
    |-> $stable(host_bus_lines_out))
    else $error("read data changed while driven");
  chk_one_chan_68: assert property (!style_is_16 && chan_select != '0
    |-> $onehot(chan_select))
    else $error("several channels chosen");
  chk_read_has_sel: assert property (chan_read_pulse |-> chan_select != '0 && !chan_write_pulse)
    else $error("read without a channel");
endmodule : quad_uart_host_checker

bind quad_uart_host_bus_select quad_uart_host_checker
  #(.NUM_CHANNELS(NUM_CHANNELS), .DATA_W(DATA_W)) u_checker (
  .clock(clock), .rst_n(rst_n), .style_is_16(style_is_16), .channel_irq(channel_irq),
  .combined_irq_out(combined_irq_out), .combined_irq_oe(combined_irq_oe),
  .modem_control_reg_bit3(modem_control_reg_bit3), .irq_enable_reg_hit(irq_enable_reg_hit),
  .irq_condition(irq_condition), .chan_read_pulse(chan_read_pulse),
  .chan_write_pulse(chan_write_pulse), .chan_select(chan_select),
  .host_bus_lines_oe(host_bus_lines_oe), .host_bus_lines_out(host_bus_lines_out));

// File: dv/quad_uart_chan_model.sv
// Purpose: Register store of the four channels behind the front end
// Assumes: Same clock as the front end
// Notes:   Keeps the last channel and address, the pulse may trail them
module quad_uart_chan_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Channel side of the front end
  input  wire logic [3:0]  chan_select,
  input  wire logic [2:0]  chan_reg_addr,
  input  wire logic        chan_write_pulse,
  input  wire logic [7:0]  chan_write_data,
  output      logic [31:0] chan_read_data
  );
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [4][8];
  logic [3:0] sel_q;
  logic [2:0] addr_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_q  <= 4'h0;
      addr_q <= 3'h0;
    end else if (chan_select != 4'h0) begin
      sel_q  <= chan_select;
      addr_q <= chan_reg_addr;
    end
  end

  // Byte stored whole, bit 0 kept as bit 0
  always_ff @(posedge clock) begin
    if (!rst_n) mem_q <= '{default: 8'h00};
    else if (chan_write_pulse) begin
      for (int i = 0; i < 4; i++) if (sel_q[i]) mem_q[i][addr_q] <= chan_write_data;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) chan_read_data[8*i +: 8] = mem_q[i][chan_reg_addr];
  end
endmodule : quad_uart_chan_model

// File: dv/quad_uart_host_bus_select_test.sv
// Purpose: Self-checking bench of the host bus front end
// Assumes: Inputs change on the falling edge
// Notes:   Writes are judged by reading them back
module quad_uart_host_bus_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0, rst_n = 1'b0, sty_lvl = 1'b0, sty_drv = 1'b0;
  logic       rd_n = 1'b1, wr_n = 1'b1, rst_pin = 1'b0, cs0_n = 1'b1, cs3_n = 1'b1;
  logic [1:0] csel = 2'h3;
  logic [2:0] ra = 3'h0;
  logic [7:0] din = 8'h00, dout;
  logic [3:0] modem_control_reg = 4'h0, ena = 4'h0, cond = 4'h0, sel, irq;
  logic [31:0] rdata;
  logic [2:0] caddr;
  logic [7:0] wdata;
  logic       oe, irq_c, irq_oe, rpul, wpul, crst, s16;
  int         error_cnt = 0, check_count = 0, cyc = 0;

  always #50 clock = ~clock;

  quad_uart_host_bus_select dut (.clock(clock), .rst_n(rst_n), .bus_style_level(sty_lvl),
    .bus_style_driven(sty_drv), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .reset_pin(rst_pin), .first_channel_select_n(cs0_n), .fourth_channel_select_n(cs3_n),
    .channel_sel_bits(csel), .reg_sel_bit0(ra[0]), .reg_sel_bit1(ra[1]), .reg_sel_bit2(ra[2]),
    .host_bus_lines_in(din), .host_bus_lines_out(dout), .host_bus_lines_oe(oe),
    .channel_irq(irq), .combined_irq_out(irq_c), .combined_irq_oe(irq_oe),
    .chan_select(sel), .chan_reg_addr(caddr), .chan_read_pulse(rpul),
    .chan_write_pulse(wpul), .chan_write_data(wdata), .chan_read_data(rdata),
    .chan_reset(crst), .style_is_16(s16), .modem_control_reg_bit3(modem_control_reg),
    .irq_enable_reg_hit(ena), .irq_condition(cond));

  quad_uart_chan_model u_chan (.clock(clock), .rst_n(rst_n), .chan_select(sel),
    .chan_reg_addr(caddr), .chan_write_pulse(wpul), .chan_write_data(wdata),
    .chan_read_data(rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  always @(posedge clock) begin
    cyc++;
    if (cyc > 4000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic set_sel(input bit m68, input int ch, input bit on);
    if (m68) begin
      cs0_n = !on;
      csel = 2'(ch);
    end else begin
      cs0_n = !(on && ch == 0);
      csel = {!(on && ch == 2), !(on && ch == 1)};
      cs3_n = !(on && ch == 3);
    end
  endtask : set_sel

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // One access, then release and idle gap; a read checks the byte put on the bus
  task automatic bus_op(input bit m68, input int ch, input logic [2:0] a, input bit wr,
                        input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    ra = a;
    din = d;
    set_sel(m68, ch, 1'b1);
    rd_n = m68 ? 1'b0 : wr;
    wr_n = !wr;
    while ((wr ? n < 5 : !rpul) && n < 12) begin
      @(posedge clock);
      #1 n++;
    end
    check(sel, 32'h1 << ch);
    check(caddr, a);
    if (wr) check(wdata, d);
    if (!wr) check(oe, 1'b1);
    if (!wr) check(dout, d);
    @(negedge clock);
    set_sel(m68, ch, 1'b0);
    rd_n = 1'b1;
    settle(1);
    wr_n = 1'b1;
    settle(5);
  endtask : bus_op

  task automatic t_style(input logic drv, input logic lvl, input logic exp);
    sty_drv = drv;
    sty_lvl = lvl;
    settle(4);
    check(s16, exp);
  endtask : t_style

  task automatic t_reset_pin(input logic pin, input logic exp);
    rst_pin = pin;
    settle(5);
    check(crst, exp);
  endtask : t_reset_pin

  task automatic t_rw(input bit m68);
    for (int ch = 0; ch < 4; ch++) bus_op(m68, ch, m68 ? 3'(7 - ch) : 3'(ch + 1), 1'b1,
                                          m68 ? {4'(ch), 4'hC} : 8'h01 << ch);
    for (int ch = 0; ch < 4; ch++) bus_op(m68, ch, m68 ? 3'(7 - ch) : 3'(ch + 1), 1'b0,
                                          m68 ? {4'(ch), 4'hC} : 8'h01 << ch);
  endtask : t_rw

  // A read strobe with no select must not open the bus
  task automatic t_no_sel(input bit m68);
    set_sel(m68, 2, 1'b0);
    rd_n = 1'b0;
    settle(6);
    check(oe, 1'b0);
    rd_n = 1'b1;
    settle(3);
  endtask : t_no_sel

  task automatic t_irq(input bit is16, input logic [3:0] m, input logic [3:0] e,
                       input logic [3:0] c);
    modem_control_reg = m;
    ena = e;
    cond = c;
    settle(2);
    check(irq, is16 ? m & e & c : 4'h0);
    check({irq_c, irq_oe}, (!is16 && |(e & c)) ? 2'h3 : 2'h0);
    {modem_control_reg, ena, cond} = 12'h000;
    settle(2);
  endtask : t_irq

  task automatic t_irq_set(input bit is16);
    t_irq(is16, 4'hF, 4'hF, 4'h5);
    t_irq(is16, 4'h6, 4'hF, 4'hF);
    t_irq(is16, 4'hF, 4'h3, 4'h6);
    t_irq(is16, 4'h0, 4'h8, 4'h8);
  endtask : t_irq_set

  initial begin
    settle(6);
    rst_n = 1'b1;
    settle(3);
    check(s16, 1'b1);
    t_reset_pin(1'b1, 1'b1);
    t_reset_pin(1'b0, 1'b0);
    t_rw(1'b0);
    t_no_sel(1'b0);
    t_irq_set(1'b1);
    t_style(1'b1, 1'b0, 1'b0);
    t_reset_pin(1'b0, 1'b1);
    t_reset_pin(1'b1, 1'b0);
    t_rw(1'b1);
    t_no_sel(1'b1);
    t_irq_set(1'b0);
    t_style(1'b1, 1'b1, 1'b1);
    final_report();
  end
endmodule : quad_uart_host_bus_select_test
